// >>> hdl/pin_sync.sv
// Two-flop synchroniser for one asynchronous pin.
`timescale 1ns/1ps
module pin_sync (
    input  wire logic clk_sys,  // System clock.
    input  wire logic rst_n,    // Synchronous reset, active low.
    input  wire logic d,        // Asynchronous level.
    output logic      q         // Synchronised level.
);
    logic [1:0] sh;

    // Only the second stage is visible outside.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sh <= 2'h0;
        end else begin
            sh <= {sh[0], d};
        end
    end

    assign q = sh[1];

endmodule : pin_sync

// >>> hdl/timer16_core.sv
// Sixteen-bit timer core with compare, capture and byte register port.
`timescale 1ns/1ps
module timer16_core
    import timer16_pkg::*;
(
    input  wire logic              clk_sys,             // System clock, 25 MHz.
    input  wire logic              rst_n,               // Synchronous reset.
    input  wire logic              timer_power_off,     // Holds the timer still.
    input  wire logic              ext_count_input,     // External count pin.
    input  wire logic              capture_input_pin,   // Capture pin.
    input  wire logic              comparator_out,      // Analog comparator level.
    input  wire bus_req_s          bus,                 // Byte register request.
    input  wire logic [FLAG_W-1:0] vector_taken,        // Vector clears a flag.
    output logic [7:0]             reg_rdata,           // Read data, next cycle.
    output logic [1:0]             compare_output_pins, // Waveform A and B.
    output logic [1:0]             compare_output_oe,   // Pin driven by timer.
    output logic [FLAG_W-1:0]      irq_req              // Request lines.
);
    timer_state_s s;
    timer_state_s next_s;
    logic         ext_s;
    logic         cap_s;
    logic         aco_s;
    logic [3:0]   wgm;
    logic [2:0]   cs;
    logic [15:0]  top;
    logic         tick;
    logic         pwm;
    logic         at_top;
    logic         cnt_wr;
    logic         cap_edge;
    logic         match_a;
    logic         match_b;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    pin_sync u_ext (.clk_sys(clk_sys), .rst_n(rst_n), .d(ext_count_input), .q(ext_s));
    pin_sync u_cap (.clk_sys(clk_sys), .rst_n(rst_n), .d(capture_input_pin), .q(cap_s));
    pin_sync u_aco (.clk_sys(clk_sys), .rst_n(rst_n), .d(comparator_out), .q(aco_s));

    // ------------------------------------------------------------
    // Mode decode and timer tick
    // ------------------------------------------------------------
    assign wgm    = {s.ctrl_b[CB_WGM_HI +: 2], s.ctrl_a[CA_WGM_LO +: 2]};
    assign cs     = s.ctrl_b[CB_CS +: 3];
    assign pwm    = FAST_MODES[wgm] | PC_MODES[wgm];
    assign at_top = (s.cnt == top);
    assign cnt_wr = bus.wr & (bus.addr == ADR_CNT_L);

    always_comb begin
        if (FIXED_TOP[wgm]) begin
            top = (wgm[1:0] == 2'h1) ? TOP_8BIT :
                  (wgm[1:0] == 2'h2) ? TOP_9BIT : TOP_10BIT;
        end else if (OCRA_TOP[wgm]) begin
            top = s.ocra;
        end else if (ICR_TOP[wgm]) begin
            top = s.icr;
        end else begin
            top = CNT_MAX;
        end
    end

    // Clock select picks prescaler tap or pin edge.
    always_comb begin
        case (cs)
            CS_OFF:      tick = 1'b0;
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = &s.pre[2:0];
            CS_DIV64:    tick = &s.pre[5:0];
            CS_DIV256:   tick = &s.pre[7:0];
            CS_DIV1024:  tick = &s.pre[9:0];
            CS_EXT_FALL: tick = s.ext_prev & ~ext_s;
            default:     tick = ~s.ext_prev & ext_s;
        endcase
        if (timer_power_off) begin
            tick = 1'b0;
        end
    end

    // Matches against the active compare values.
    assign match_a  = tick & ~s.blk & (s.cnt == s.ocra);
    assign match_b  = tick & ~s.blk & (s.cnt == s.ocrb);
    assign cap_edge = (s.cap_flt != s.cap_prev) & (s.cap_flt == s.ctrl_b[CB_EDGE]) &
                      ~timer_power_off;

    // Next waveform level for one channel.
    function automatic logic oc_step(input logic [1:0] com, input logic oc,
                                     input logic hit, input logic wrap,
                                     input logic [3:0] m, input logic dn);
        logic r;
        r = oc;
        if (FAST_MODES[m]) begin
            if (hit && com == COM_TOG) r = ~oc;
            if (hit && com[1]) r = com[0];
            if (wrap && com[1]) r = ~com[0];
        end else if (PC_MODES[m]) begin
            if (hit && com == COM_TOG) r = ~oc;
            if (hit && com[1]) r = com[0] ^ dn;
        end else if (hit) begin
            r = (com == COM_TOG) ? ~oc : (com == COM_CLR) ? 1'b0 :
                (com == COM_SET) ? 1'b1 : oc;
        end
        return r;
    endfunction : oc_step

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic       cap_src;
        logic [FLAG_W-1:0] ev;
        next_s  = s;
        com_a   = s.ctrl_a[CA_COMA +: 2];
        com_b   = s.ctrl_a[CA_COMB +: 2];
        cap_src = s.ctrl_c[CC_ACO] ? aco_s : cap_s;
        ev      = '0;
        next_s.rdata    = RST_BYTE;
        next_s.pre      = s.pre + PRE_W'(1);
        next_s.ext_prev = ext_s;
        next_s.cap_prev = s.cap_flt;

        // Filter passes a level after four equal samples.
        if (!s.ctrl_b[CB_NC] || cap_src == s.cap_flt) begin
            next_s.nc_cnt  = 2'h0;
            next_s.cap_flt = s.ctrl_b[CB_NC] ? s.cap_flt : cap_src;
        end else if (s.nc_cnt == NC_LAST) begin
            next_s.nc_cnt  = 2'h0;
            next_s.cap_flt = cap_src;
        end else begin
            next_s.nc_cnt = s.nc_cnt + 2'h1;
        end

        // Counter counts only on a tick; a low-byte count write also loads it.
        if (tick) begin
            next_s.blk = 1'b0;
            if (PC_MODES[wgm]) begin
                if (!s.down) begin
                    next_s.cnt  = at_top ? s.cnt - 16'h0001 : s.cnt + 16'h0001;
                    next_s.down = at_top;
                end else begin
                    // Turn round and flag overflow at BOTTOM.
                    next_s.cnt   = (s.cnt == CNT_BOTTOM) ? s.cnt + 16'h0001
                                                         : s.cnt - 16'h0001;
                    next_s.down  = (s.cnt != CNT_BOTTOM);
                    ev[FLG_TOV]  = (s.cnt == CNT_BOTTOM);
                end
            end else if (FAST_MODES[wgm] || CTC_MODES[wgm]) begin
                next_s.cnt  = at_top ? CNT_BOTTOM : s.cnt + 16'h0001;
                next_s.down = 1'b0;
                ev[FLG_TOV] = FAST_MODES[wgm] ? at_top : (s.cnt == CNT_MAX);
            end else begin
                next_s.cnt  = s.cnt + 16'h0001;
                next_s.down = 1'b0;
                ev[FLG_TOV] = (s.cnt == CNT_MAX);
            end
        end

        ev[FLG_OCA] = match_a;
        ev[FLG_OCB] = match_b;

        // Capture the count unless capture holds TOP.
        if (cap_edge && !ICR_TOP[wgm]) begin
            next_s.icr   = s.cnt;
            ev[FLG_ICF]  = 1'b1;
        end

        // Compare A as PWM TOP only toggles or stays off.
        next_s.oc[0] = oc_step(com_a, s.oc[0], match_a, tick & at_top, wgm, s.down);
        next_s.oc[1] = oc_step(com_b, s.oc[1], match_b, tick & at_top, wgm, s.down);
        next_s.oe[0] = (com_a != 2'h0) && !(pwm && OCRA_TOP[wgm] && com_a != COM_TOG);
        next_s.oe[1] = (com_b != 2'h0) && !(pwm && com_b == COM_TOG);

        if (bus.wr) begin
            case (bus.addr)
                ADR_CTRL_A: next_s.ctrl_a = bus.wdata;
                ADR_CTRL_B: next_s.ctrl_b = bus.wdata;
                ADR_CTRL_C: next_s.ctrl_c = bus.wdata;
                ADR_CNT_L: begin
                    // Low write commits temp high byte.
                    next_s.cnt = {s.temp, bus.wdata};
                    next_s.blk = 1'b1;
                end
                ADR_CAP_L:  next_s.icr      = {s.temp, bus.wdata};
                ADR_CMPA_L: next_s.ocra_buf = {s.temp, bus.wdata};
                ADR_CMPB_L: next_s.ocrb_buf = {s.temp, bus.wdata};
                ADR_CNT_H, ADR_CAP_H, ADR_CMPA_H, ADR_CMPB_H: next_s.temp = bus.wdata;
                ADR_FLAG:   next_s.flags    = s.flags & ~bus.wdata[FLAG_W-1:0];
                ADR_MASK:   next_s.mask     = bus.wdata[FLAG_W-1:0];
                default:    next_s.temp     = s.temp;
            endcase
        end

        // Double-buffered compare values load at TOP in PWM.
        if (!pwm || (tick && at_top)) begin
            next_s.ocra = s.ocra_buf;
            next_s.ocrb = s.ocrb_buf;
        end

        // Four sources; a set beats any clear.
        next_s.flags = (next_s.flags & ~vector_taken) | ev;
        // Request follows flag and mask together.
        next_s.irq   = next_s.flags & next_s.mask;

        if (bus.rd) begin
            case (bus.addr)
                ADR_CTRL_A: next_s.rdata = s.ctrl_a;
                ADR_CTRL_B: next_s.rdata = s.ctrl_b;
                ADR_CTRL_C: next_s.rdata = s.ctrl_c;
                ADR_CNT_L: begin
                    // Low read latches the high byte.
                    next_s.rdata = s.cnt[7:0];
                    next_s.temp  = s.cnt[15:8];
                end
                ADR_CAP_L: begin
                    next_s.rdata = s.icr[7:0];
                    next_s.temp  = s.icr[15:8];
                end
                ADR_CNT_H, ADR_CAP_H: next_s.rdata = s.temp;
                // Compare reads come straight from the buffer.
                ADR_CMPA_L: next_s.rdata = s.ocra_buf[7:0];
                ADR_CMPA_H: next_s.rdata = s.ocra_buf[15:8];
                ADR_CMPB_L: next_s.rdata = s.ocrb_buf[7:0];
                ADR_CMPB_H: next_s.rdata = s.ocrb_buf[15:8];
                ADR_FLAG:   next_s.rdata = {4'h0, s.flags};
                ADR_MASK:   next_s.rdata = {4'h0, s.mask};
                default:    next_s.rdata = RST_BYTE;
            endcase
        end
    end

    // State register.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata           = s.rdata;
    assign compare_output_pins = s.oc;
    assign compare_output_oe   = s.oe;
    assign irq_req             = s.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_hi_write;
        bus.wr && bus.addr == ADR_CNT_H;
    endsequence
    sequence s_lo_write;
        bus.wr && bus.addr == ADR_CNT_L && !bus.rd;
    endsequence

    property p_stopped;
        (cs == CS_OFF && !cnt_wr) |=> $stable(s.cnt);
    endproperty
    a_stopped: assert property (p_stopped) else $error("count moved with no clock");

    property p_pair_write;
        (s_hi_write ##1 s_lo_write) |=> s.cnt == {$past(bus.wdata, 2), $past(bus.wdata)};
    endproperty
    a_pair_write: assert property (p_pair_write) else $error("16-bit write wrong");

    property p_cmp_read;
        (bus.rd && bus.addr == ADR_CMPA_H) |=> reg_rdata == $past(s.ocra_buf[15:8]);
    endproperty
    a_cmp_read: assert property (p_cmp_read) else $error("compare read wrong");

    property p_irq;
        irq_req == (s.flags & s.mask);
    endproperty
    a_irq: assert property (p_irq) else $error("request not flag and mask");

    property p_max_wrap;
        (tick && wgm == 4'h0 && s.cnt == CNT_MAX && !bus.wr)
            |=> s.cnt == CNT_BOTTOM && s.flags[FLG_TOV];
    endproperty
    a_max_wrap: assert property (p_max_wrap) else $error("no wrap at MAX");

    property p_top8;
        (tick && wgm == 4'h5 && s.cnt == TOP_8BIT && !bus.wr) |=> s.cnt == CNT_BOTTOM;
    endproperty
    a_top8: assert property (p_top8) else $error("fixed TOP not honoured");

    property p_match;
        match_a |=> s.flags[FLG_OCA] ##1 $past(s.flags[FLG_OCA]);
    endproperty
    a_match: assert property (p_match) else $error("compare flag not set");

    property p_capture;
        (cap_edge && !ICR_TOP[wgm] && !bus.wr)
            |=> s.icr == $past(s.cnt) && s.flags[FLG_ICF];
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    property p_power;
        (timer_power_off && !cnt_wr) [*2] |-> $stable(s.cnt);
    endproperty
    a_power: assert property (p_power) else $error("counted while off");

endmodule : timer16_core

// >>> hdl/timer16_pkg.sv
// Constants, modes and carrier types shared by the 16-bit timer core.
package timer16_pkg;

    // ------------------------------------------------------------
    // Byte register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_CTRL_A = 4'h0;
    localparam logic [3:0] ADR_CTRL_B = 4'h1;
    localparam logic [3:0] ADR_CTRL_C = 4'h2;
    localparam logic [3:0] ADR_CNT_L  = 4'h4;
    localparam logic [3:0] ADR_CNT_H  = 4'h5;
    localparam logic [3:0] ADR_CAP_L  = 4'h6;
    localparam logic [3:0] ADR_CAP_H  = 4'h7;
    localparam logic [3:0] ADR_CMPA_L = 4'h8;
    localparam logic [3:0] ADR_CMPA_H = 4'h9;
    localparam logic [3:0] ADR_CMPB_L = 4'ha;
    localparam logic [3:0] ADR_CMPB_H = 4'hb;
    localparam logic [3:0] ADR_FLAG   = 4'hc;
    localparam logic [3:0] ADR_MASK   = 4'hd;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CA_COMA   = 6;  // Control A bits 7:6, channel A output mode.
    localparam int CA_COMB   = 4;  // Control A bits 5:4, channel B output mode.
    localparam int CA_WGM_LO = 0;  // Control A bits 1:0, mode low bits.
    localparam int CB_NC     = 7;  // Control B bit 7, noise canceller enable.
    localparam int CB_EDGE   = 6;  // Control B bit 6, capture on rising edge.
    localparam int CB_WGM_HI = 3;  // Control B bits 4:3, mode high bits.
    localparam int CB_CS     = 0;  // Control B bits 2:0, clock select.
    localparam int CC_ACO    = 0;  // Control C bit 0, capture from comparator.
    localparam int FLG_TOV   = 0;
    localparam int FLG_OCA   = 1;
    localparam int FLG_OCB   = 2;
    localparam int FLG_ICF   = 3;
    localparam int FLAG_W    = 4;

    // ------------------------------------------------------------
    // Counter values, modes and codes
    // ------------------------------------------------------------
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hffff;
    localparam logic [15:0] TOP_8BIT   = 16'h00ff;
    localparam logic [15:0] TOP_9BIT   = 16'h01ff;
    localparam logic [15:0] TOP_10BIT  = 16'h03ff;
    localparam logic [15:0] FAST_MODES = 16'hc0e0;  // One bit per mode number.
    localparam logic [15:0] PC_MODES   = 16'h0f0e;
    localparam logic [15:0] CTC_MODES  = 16'h1010;
    localparam logic [15:0] ICR_TOP    = 16'h5500;
    localparam logic [15:0] OCRA_TOP   = 16'h8a10;
    localparam logic [15:0] FIXED_TOP  = 16'h00ee;
    localparam logic [2:0]  CS_OFF     = 3'h0;
    localparam logic [2:0]  CS_DIV1    = 3'h1;
    localparam logic [2:0]  CS_DIV8    = 3'h2;
    localparam logic [2:0]  CS_DIV64   = 3'h3;
    localparam logic [2:0]  CS_DIV256  = 3'h4;
    localparam logic [2:0]  CS_DIV1024 = 3'h5;
    localparam logic [2:0]  CS_EXT_FALL = 3'h6;
    localparam logic [1:0]  COM_TOG    = 2'h1;
    localparam logic [1:0]  COM_CLR    = 2'h2;
    localparam logic [1:0]  COM_SET    = 2'h3;
    localparam int          PRE_W      = 10;
    localparam logic [1:0]  NC_LAST    = 2'h3;  // Four equal samples pass.
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_WORD   = 16'h0000;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    typedef struct packed {
        logic [7:0]        ctrl_a;
        logic [7:0]        ctrl_b;
        logic [7:0]        ctrl_c;
        logic [15:0]       cnt;
        logic              down;
        logic              blk;
        logic [15:0]       ocra_buf;
        logic [15:0]       ocrb_buf;
        logic [15:0]       ocra;
        logic [15:0]       ocrb;
        logic [15:0]       icr;
        logic [7:0]        temp;
        logic [FLAG_W-1:0] flags;
        logic [FLAG_W-1:0] mask;
        logic [FLAG_W-1:0] irq;
        logic [PRE_W-1:0]  pre;
        logic [1:0]        nc_cnt;
        logic              cap_flt;
        logic              cap_prev;
        logic              ext_prev;
        logic [1:0]        oc;
        logic [1:0]        oe;
        logic [7:0]        rdata;
    } timer_state_s;

endpackage : timer16_pkg

// >>> verification/cpu_bus_model.sv
// Processor-side byte bus model that drives the timer core.
`timescale 1ns/1ps
module cpu_bus_model
    import timer16_pkg::*;
(
    input  wire logic              clk_sys,      // System clock.
    input  wire logic [7:0]        rdata,        // Read data from the timer.
    output bus_req_s               bus,          // Byte request.
    output logic [FLAG_W-1:0]      vector_taken, // Vector clears a flag.
    output logic                   power_off     // Timer hold request.
);
    // Idle bus at time zero; the timer starts powered.
    // power bit low
    initial begin
        bus = '0;
        vector_taken = '0;
        power_off = 1'b0;
    end

    // One byte write, held across one sampling edge.
    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        bus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk_sys);
        bus = '0;
    endtask : wr8

    // One byte read; the answer is taken the cycle after the request.
    task automatic rd8(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        bus = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk_sys);
        d = rdata;
        bus = '0;
    endtask : rd8

    // Word write, high byte then low byte on consecutive edges.
    task automatic wr16(input logic [3:0] lo, input logic [15:0] d);
        @(negedge clk_sys);
        bus = '{addr: lo + 4'h1, wdata: d[15:8], wr: 1'b1, rd: 1'b0};
        @(negedge clk_sys);
        bus = '{addr: lo, wdata: d[7:0], wr: 1'b1, rd: 1'b0};
        @(negedge clk_sys);
        bus = '0;
    endtask : wr16

    // Word read, low byte then high byte on consecutive edges.
    task automatic rd16(input logic [3:0] lo, output logic [15:0] d);
        @(negedge clk_sys);
        bus = '{addr: lo, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk_sys);
        d[7:0] = rdata;
        bus = '{addr: lo + 4'h1, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk_sys);
        d[15:8] = rdata;
        bus = '0;
    endtask : rd16

    // Timer hold level, changed on a falling edge.
    task automatic hold(input logic v);
        @(negedge clk_sys);
        power_off = v;
    endtask : hold

    // One-cycle vector pulse on the chosen flags.
    task automatic vec(input logic [FLAG_W-1:0] m);
        @(negedge clk_sys);
        vector_taken = m;
        @(negedge clk_sys);
        vector_taken = '0;
    endtask : vec
endmodule : cpu_bus_model

// >>> verification/timer16_core_tb.sv
// Self-checking bench for the sixteen-bit timer core.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module timer16_core_tb
    import timer16_pkg::*;
;
    logic              clk_sys = 1'b0;
    logic              rst_n   = 1'b0;
    logic              ext_pin = 1'b1;
    logic              cap_pin = 1'b0;
    logic              cmp_out = 1'b0;
    logic              power_off;
    bus_req_s          bus;
    logic [FLAG_W-1:0] vtaken;
    logic [FLAG_W-1:0] irq;
    logic [7:0]        rdata;
    logic [1:0]        oc_pin;
    logic [1:0]        oc_oe;
    logic [15:0]       w;
    logic [7:0]        b;
    int                checks     = 0;
    int                mismatches = 0;

    // Clock of 40 ns period.
    always #20 clk_sys = ~clk_sys;

    timer16_core timer16_core_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .timer_power_off(power_off),
        .ext_count_input(ext_pin), .capture_input_pin(cap_pin),
        .comparator_out(cmp_out), .bus(bus), .vector_taken(vtaken),
        .reg_rdata(rdata), .compare_output_pins(oc_pin),
        .compare_output_oe(oc_oe), .irq_req(irq));

    cpu_bus_model cpu_bus_model_inst (
        .clk_sys(clk_sys), .rdata(rdata), .bus(bus),
        .vector_taken(vtaken), .power_off(power_off));

    // Waits a bounded time for one request line to rise.
    task automatic wait_irq(input int i, input string nm);
        int n;
        n = 0;
        while (irq[i] !== 1'b1 && n < 80) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK(nm, 1'b1, irq[i])
    endtask : wait_irq

    // Stopped counter, shared high byte and direct compare reads.
    task automatic t_temp();
        cpu_bus_model_inst.wr16(ADR_CNT_L, 16'h01ff);
        repeat (10) @(negedge clk_sys);
        cpu_bus_model_inst.rd16(ADR_CNT_L, w);
        `CHK("count held", 16'h01ff, w)
        cpu_bus_model_inst.hold(1'b1);
        cpu_bus_model_inst.wr8(ADR_CTRL_B, {5'h00, CS_DIV1});
        repeat (10) @(negedge clk_sys);
        cpu_bus_model_inst.wr8(ADR_CTRL_B, 8'h00);
        cpu_bus_model_inst.hold(1'b0);
        cpu_bus_model_inst.rd16(ADR_CNT_L, w);
        `CHK("count held off", 16'h01ff, w)
        cpu_bus_model_inst.wr16(ADR_CMPA_L, 16'h1234);
        cpu_bus_model_inst.wr8(ADR_CNT_H, 8'h55);
        cpu_bus_model_inst.rd8(ADR_CMPA_H, b);
        `CHK("compare high", 8'h12, b)
        cpu_bus_model_inst.wr8(ADR_CNT_L, 8'h66);
        cpu_bus_model_inst.rd16(ADR_CNT_L, w);
        `CHK("shared temp", 16'h5566, w)
    endtask : t_temp

    // Wrap through MAX, masking, vector clear, write-one clear and fixed TOP.
    task automatic t_ovf();
        cpu_bus_model_inst.wr16(ADR_CMPA_L, 16'h0000);
        cpu_bus_model_inst.wr8(ADR_MASK, 8'h01);
        cpu_bus_model_inst.wr16(ADR_CNT_L, 16'hfffd);
        cpu_bus_model_inst.wr8(ADR_CTRL_B, {5'h00, CS_DIV1});
        wait_irq(FLG_TOV, "overflow irq");
        cpu_bus_model_inst.wr8(ADR_CTRL_B, 8'h00);
        cpu_bus_model_inst.rd8(ADR_FLAG, b);
        `CHK("flags", 8'h07, b)
        `CHK("masked irq", 4'h1, irq)
        cpu_bus_model_inst.vec(4'h1);
        repeat (2) @(negedge clk_sys);
        `CHK("vector clear", 4'h0, irq)
        cpu_bus_model_inst.wr8(ADR_FLAG, 8'h06);
        cpu_bus_model_inst.rd8(ADR_FLAG, b);
        `CHK("flag clear", 8'h00, b)
        cpu_bus_model_inst.wr16(ADR_CNT_L, 16'h00fc);
        cpu_bus_model_inst.wr8(ADR_CTRL_A, 8'h01);
        cpu_bus_model_inst.wr8(ADR_CTRL_B, {5'h01, CS_DIV1});
        wait_irq(FLG_TOV, "fixed top irq");
        cpu_bus_model_inst.wr8(ADR_CTRL_B, 8'h00);
        cpu_bus_model_inst.rd16(ADR_CNT_L, w);
        `CHK("fixed top wrap", 8'h00, w[15:8])
        cpu_bus_model_inst.wr8(ADR_FLAG, 8'h0f);
    endtask : t_ovf

    // Compare A match toggles its pin and raises its request.
    task automatic t_cmp();
        cpu_bus_model_inst.wr8(ADR_MASK, 8'h02);
        cpu_bus_model_inst.wr8(ADR_CTRL_A, {COM_TOG, 6'h00});
        cpu_bus_model_inst.wr16(ADR_CMPA_L, 16'h0040);
        cpu_bus_model_inst.wr16(ADR_CNT_L, 16'h0030);
        cpu_bus_model_inst.wr8(ADR_CTRL_B, {5'h00, CS_DIV1});
        wait_irq(FLG_OCA, "match A irq");
        cpu_bus_model_inst.wr8(ADR_CTRL_B, 8'h00);
        `CHK("pin A driven", 1'b1, oc_oe[0])
        `CHK("pin A toggled", 1'b1, oc_pin[0])
    endtask : t_cmp

    // Three pin pulses counted on the falling, then the rising edge.
    task automatic t_ext();
        for (int e = 0; e < 2; e++) begin
            cpu_bus_model_inst.wr16(ADR_CNT_L, 16'h0100);
            cpu_bus_model_inst.wr8(ADR_CTRL_B, {5'h00, CS_EXT_FALL + 3'(e)});
            repeat (3) begin
                ext_pin = 1'b0;
                repeat (6) @(negedge clk_sys);
                ext_pin = 1'b1;
                repeat (6) @(negedge clk_sys);
            end
            cpu_bus_model_inst.wr8(ADR_CTRL_B, 8'h00);
            cpu_bus_model_inst.rd16(ADR_CNT_L, w);
            `CHK("pin count", 16'h0103, w)
        end
    endtask : t_ext

    // Drives the capture source chosen by s.
    task automatic set_src(input int s, input logic v);
        if (s == 0) begin
            cap_pin = v;
        end else begin
            cmp_out = v;
        end
    endtask : set_src

    // Filtered capture from the pin, then from the comparator.
    task automatic t_cap();
        for (int s = 0; s < 2; s++) begin
            cpu_bus_model_inst.wr8(ADR_CTRL_C, {7'h00, s[0]});
            cpu_bus_model_inst.wr8(ADR_CTRL_B, 8'hc0);
            cpu_bus_model_inst.wr8(ADR_MASK, 8'h08);
            cpu_bus_model_inst.wr8(ADR_FLAG, 8'h0f);
            cpu_bus_model_inst.wr16(ADR_CNT_L, 16'h0abc + 16'(s));
            set_src(s, 1'b1);
            repeat (2) @(negedge clk_sys);
            set_src(s, 1'b0);
            repeat (14) @(negedge clk_sys);
            `CHK("spike ignored", 1'b0, irq[FLG_ICF])
            set_src(s, 1'b1);
            wait_irq(FLG_ICF, "capture irq");
            cpu_bus_model_inst.rd16(ADR_CAP_L, w);
            `CHK("capture value", 16'h0abc + 16'(s), w)
        end
    endtask : t_cap

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // Reset for four cycles, then every scenario in turn.
    initial begin
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        t_temp();
        t_ovf();
        t_cmp();
        t_ext();
        t_cap();
        close_out();
    end

    // Watchdog well beyond the few hundred cycles the scenarios need.
    initial begin
        #(40 * 20000);
        mismatches++;
        close_out();
    end
endmodule : timer16_core_tb
